// [src/core_pkg.sv]
// Constants shared by the core flag, program counter and stack logic.
// Assumes register indices are word indices on the AXI4-Lite bus.
package core_pkg;
  // ==========================================================
  // Register indices (byte address is four times the index)
  localparam logic [8:0] IDX_INDIRECT = 9'h000;
  localparam logic [8:0] IDX_PC_LOW = 9'h002;
  localparam logic [8:0] IDX_STATUS = 9'h003;
  localparam logic [8:0] IDX_POINTER = 9'h004;
  localparam logic [8:0] IDX_PC_LATCH = 9'h00A;
  localparam logic [8:0] IDX_GLOBAL = 9'h00B;
  localparam logic [8:0] IDX_FLAGS_A = 9'h00C;
  localparam logic [8:0] IDX_FLAGS_B = 9'h00D;
  localparam logic [8:0] IDX_ENABLE_A = 9'h08C;
  localparam logic [8:0] IDX_ENABLE_B = 9'h08D;
  localparam logic [8:0] IDX_RESET_CAUSE = 9'h08E;
  // ==========================================================
  // Implemented-bit masks
  localparam logic [7:0] FLAGS_A_MASK = 8'h4F;
  localparam logic [7:0] FLAGS_B_MASK = 8'h10;
  localparam logic [7:0] RESET_CAUSE_MASK = 8'h03;
  localparam logic [7:0] LATCH_MASK = 8'h1F;
  localparam logic [7:0] GLOBAL_MASK = 8'hC0;
  // ==========================================================
  // Field positions
  localparam int BIT_CONVERTER = 6;
  localparam int BIT_SERIAL = 3;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_TIMER_B = 1;
  localparam int BIT_TIMER_A = 0;
  localparam int BIT_NV_WRITE = 4;
  localparam int BIT_POR = 1;
  localparam int BIT_BOR = 0;
  localparam int BIT_GIE = 7;
  localparam int BIT_PERIPHERAL_IRQ_ENABLE = 6;
  localparam int BIT_BANK_SEL = 7;
  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] INT_VECTOR = 13'h0004;
  localparam int STACK_DEPTH = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Capture/compare unit operating mode
  typedef enum logic [1:0] {
    CC_CAPTURE = 2'h0,
    CC_COMPARE = 2'h1,
    CC_PWM = 2'h2
  } capcmp_mode_t;
endpackage

// [src/core_links_if.sv]
// Carriers between the core top and its flag bank and return stack.
// Assumes all parties share one clock.
`timescale 1ns/1ns
// ==========================================================
// Flag bank link
interface flag_if;
  logic [7:0] setA; // Event pulses, first bank
  logic [7:0] setB; // Event pulses, second bank
  logic [7:0] wdata; // Software write data
  logic wrA; // Software write, first bank
  logic wrB; // Software write, second bank
  logic [7:0] flagsA; // Flag state, first bank
  logic [7:0] flagsB; // Flag state, second bank
  modport bank(input setA, setB, wdata, wrA, wrB, output flagsA, flagsB);
  modport user(output setA, setB, wdata, wrA, wrB, input flagsA, flagsB);
endinterface
// ==========================================================
// Return stack link
interface stack_if;
  logic push; // Push request
  logic pop; // Pop request
  logic [12:0] pushData; // Address to save
  logic [12:0] topData; // Most recently saved address
  modport stack(input push, pop, pushData, output topData);
  modport user(output push, pop, pushData, input topData);
endinterface

// [src/event_flags.sv]
// Sticky peripheral event flags, two banks of eight.
// Assumes event pulses come from logic on the same clock.
`timescale 1ns/1ns
module event_flags
  import core_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  flag_if.bank fl
);
  // ==========================================================
  // Flag storage
  logic [7:0] flagsA_ff; // First bank
  logic [7:0] flagsB_ff; // Second bank

  // One flop pair per bit; unimplemented bits never leave zero
  for (genvar i = 0; i < 8; i++) begin : g_bit
    // Event sets regardless of enables; set beats a clear
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        flagsA_ff[i] <= 1'b0;
      end else if (FLAGS_A_MASK[i]) begin
        if (fl.setA[i]) begin
          flagsA_ff[i] <= 1'b1;
        end else if (fl.wrA) begin
          flagsA_ff[i] <= fl.wdata[i];
        end
      end
    end
    // Second bank, nonvolatile write flag only
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        flagsB_ff[i] <= 1'b0;
      end else if (FLAGS_B_MASK[i]) begin
        if (fl.setB[i]) begin
          flagsB_ff[i] <= 1'b1;
        end else if (fl.wrB) begin
          flagsB_ff[i] <= fl.wdata[i];
        end
      end
    end
  end

  assign fl.flagsA = flagsA_ff;
  assign fl.flagsB = flagsB_ff;
endmodule

// [src/return_stack.sv]
// Eight-entry circular return address stack.
// Assumes push and pop never arrive in the same cycle.
`timescale 1ns/1ns
module return_stack
  import core_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  stack_if.stack st
);
  // ==========================================================
  // Storage and hidden pointer
  logic [12:0] entry_ff [STACK_DEPTH]; // Saved addresses
  logic [2:0] ptr_ff; // Next free slot, not visible to software
  logic [2:0] topIdx; // Slot of newest entry

  // Pointer wraps silently; no overflow or underflow status
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ptr_ff <= 3'h0;
    end else if (st.push) begin
      ptr_ff <= ptr_ff + 3'h1;
    end else if (st.pop) begin
      ptr_ff <= ptr_ff - 3'h1;
    end
  end

  // Ninth push lands on the first slot again
  for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
    always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
        entry_ff[i] <= PC_RESET;
      end else if (st.push && ptr_ff == 3'(i)) begin
        entry_ff[i] <= st.pushData;
      end
    end
  end

  assign topIdx = ptr_ff - 3'h1;
  assign st.topData = entry_ff[topIdx];
endmodule

// [src/core_flags_pc_stack_indirect.sv]
// Core special-function registers: peripheral flags and enables,
// reset cause, program counter with latch, return stack, indirect port.
// Assumes the instruction core and peripherals share this clock and
// send one-cycle pulses; software reaches registers over AXI4-Lite.
`timescale 1ns/1ns
// How it works
// - Flags set regardless of any enable
// - Conversion done sets bit 6
// - Serial transfer sets bit 3
// - Capture or compare sets bit 2
// - Period match bit 1, overflow bit 0
// - Unimplemented bits read zero
// - Nonvolatile write enable at bit 4
// - Nonvolatile write flag at bit 4
// - Power-on reset clears power-on bit
// - Brown-out reset clears brown-out bit
// - Brown-out bit undefined with detector off
// - 13-bit counter, low byte accessible
// - Every reset clears upper counter bits
// - Low-byte write loads upper from latch
// - Call or jump uses latch bits 4:3
// - Eight by 13-bit hidden return stack
// - Push on call/vector, pop on returns
// - Stack wraps circularly after eight pushes
// - No overflow or underflow indication
// - Indirect port accesses pointed register
// - Self-pointing reads zero, writes nothing
// - Target is bank bit over pointer
// - Peripheral enable gates peripheral requests
module core_flags_pc_stack_indirect
  import core_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral events
  input wire logic converterDone,
  input wire logic serialDone,
  input wire logic capcmpEvent,
  input wire capcmp_mode_t capcmpMode,
  input wire logic timerBMatch,
  input wire logic timerAOverflow,
  input wire logic nvWriteDone,
  // Reset causes other than power-on
  input wire logic brownoutReset,
  input wire logic otherReset,
  input wire logic brownoutDetectorEnable,
  // Instruction core
  input wire logic stepReq,
  input wire logic gotoReq,
  input wire logic callReq,
  input wire logic vectorReq,
  input wire logic popReq,
  input wire logic [10:0] targetAddr,
  output logic [12:0] pcOut,
  output logic peripheralIrq
);
  // ==========================================================
  // Internal links
  flag_if fl();
  stack_if st();

  // ==========================================================
  // Software-visible storage
  logic [7:0] pcLatch_ff; // Upper counter latch, bits 4:0 used
  logic [7:0] pointer_ff; // Indirect file pointer
  logic bankSel_ff; // Indirect bank select
  logic [7:0] globalCtl_ff; // Global and peripheral enables
  logic [7:0] enableA_ff; // First bank enables
  logic [7:0] enableB_ff; // Second bank enables
  logic [7:0] resetCause_ff; // Power-on and brown-out status
  logic [12:0] pc_ff; // Program counter
  logic irq_ff; // Peripheral request to core

  // ==========================================================
  // Bus slave state
  logic awHeld_ff; // Write address captured
  logic wHeld_ff; // Write data captured
  logic [8:0] awIdx_ff; // Captured write index
  logic [7:0] wData_ff; // Captured low byte
  logic wStrb_ff; // Low lane enable
  logic awready_ff; // Address ready
  logic wready_ff; // Data ready
  logic bvalid_ff; // Write answer pending
  logic [1:0] bresp_ff; // Write answer code
  logic arready_ff; // Read address ready
  logic rvalid_ff; // Read answer pending
  logic [1:0] rresp_ff; // Read answer code
  logic [31:0] rdata_ff; // Read answer data

  // ==========================================================
  // Decode helpers
  logic [8:0] wrIdx; // Resolved write target
  logic [8:0] rdIdx; // Resolved read target
  logic wrExec; // Write performed this cycle
  logic wrEn; // Low lane really written
  logic wrHit; // Write target mapped
  logic [7:0] rdVal; // Read value
  logic rdHit; // Read target mapped
  logic anyReset; // Synchronous reset causes

  // Indirect port redirects to bank bit over pointer
  function automatic logic [8:0] resolve(input logic [8:0] idx, input logic bank,
                                         input logic [7:0] ptr);
    resolve = (idx == IDX_INDIRECT) ? {bank, ptr} : idx;
  endfunction

  // Mapped register test
  function automatic logic mapped(input logic [8:0] idx);
    case (idx)
      IDX_INDIRECT, IDX_PC_LOW, IDX_STATUS, IDX_POINTER, IDX_PC_LATCH,
      IDX_GLOBAL, IDX_FLAGS_A, IDX_FLAGS_B, IDX_ENABLE_A, IDX_ENABLE_B,
      IDX_RESET_CAUSE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  assign wrIdx = resolve(awIdx_ff, bankSel_ff, pointer_ff);
  assign rdIdx = resolve(s_axi_araddr[10:2], bankSel_ff, pointer_ff);
  assign wrExec = awHeld_ff && wHeld_ff && !bvalid_ff;
  assign wrHit = mapped(wrIdx);
  // Self-pointing write does nothing
  assign wrEn = wrExec && wStrb_ff && wrHit && wrIdx != IDX_INDIRECT;
  assign anyReset = (brownoutReset && brownoutDetectorEnable) || otherReset;

  // ==========================================================
  // Read multiplexer
  // Unimplemented bits come back as zero
  always_comb begin
    rdHit = 1'b1;
    case (rdIdx)
      IDX_INDIRECT: rdVal = 8'h00; // Self-pointing read
      IDX_PC_LOW: rdVal = pc_ff[7:0]; // Upper bits hidden
      IDX_STATUS: rdVal = {bankSel_ff, 7'h00};
      IDX_POINTER: rdVal = pointer_ff;
      IDX_PC_LATCH: rdVal = pcLatch_ff & LATCH_MASK;
      IDX_GLOBAL: rdVal = globalCtl_ff & GLOBAL_MASK;
      IDX_FLAGS_A: rdVal = fl.flagsA & FLAGS_A_MASK;
      IDX_FLAGS_B: rdVal = fl.flagsB & FLAGS_B_MASK;
      IDX_ENABLE_A: rdVal = enableA_ff & FLAGS_A_MASK;
      IDX_ENABLE_B: rdVal = enableB_ff & FLAGS_B_MASK;
      IDX_RESET_CAUSE: rdVal = resetCause_ff & RESET_CAUSE_MASK;
      default: begin
        rdVal = 8'h00;
        rdHit = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Write address channel
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      awready_ff <= 1'b1;
      awIdx_ff <= 9'h000;
    end else if (s_axi_awvalid && awready_ff) begin
      awHeld_ff <= 1'b1;
      awready_ff <= 1'b0;
      awIdx_ff <= s_axi_awaddr[10:2];
    end else if (wrExec) begin
      awHeld_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      awready_ff <= 1'b1; // Reopen after answer taken
    end
  end

  // Write data channel
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wHeld_ff <= 1'b0;
      wready_ff <= 1'b1;
      wData_ff <= 8'h00;
      wStrb_ff <= 1'b0;
    end else if (s_axi_wvalid && wready_ff) begin
      wHeld_ff <= 1'b1;
      wready_ff <= 1'b0;
      wData_ff <= s_axi_wdata[7:0];
      wStrb_ff <= s_axi_wstrb[0];
    end else if (wrExec) begin
      wHeld_ff <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      wready_ff <= 1'b1;
    end
  end

  // Write answer; unmapped index answers with slave error
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wrExec) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Read channel: answer one cycle after the address is taken
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (s_axi_arvalid && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b1;
      rresp_ff <= rdHit ? RESP_OKAY : RESP_SLVERR;
      rdata_ff <= {24'h00_0000, rdVal};
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ==========================================================
  // Plain software registers
  // Pointer and bank select for indirect access
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pointer_ff <= REG_RESET;
      bankSel_ff <= 1'b0;
    end else if (wrEn && wrIdx == IDX_POINTER) begin
      pointer_ff <= wData_ff;
    end else if (wrEn && wrIdx == IDX_STATUS) begin
      bankSel_ff <= wData_ff[BIT_BANK_SEL];
    end
  end

  // Latch is untouched by stack traffic
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pcLatch_ff <= REG_RESET;
    end else if (wrEn && wrIdx == IDX_PC_LATCH) begin
      pcLatch_ff <= wData_ff & LATCH_MASK;
    end
  end

  // Global enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      globalCtl_ff <= REG_RESET;
    end else if (wrEn && wrIdx == IDX_GLOBAL) begin
      globalCtl_ff <= wData_ff & GLOBAL_MASK;
    end
  end

  // Individual enables; second bank holds the write enable
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      enableA_ff <= REG_RESET;
      enableB_ff <= REG_RESET;
    end else if (wrEn && wrIdx == IDX_ENABLE_A) begin
      enableA_ff <= wData_ff & FLAGS_A_MASK;
    end else if (wrEn && wrIdx == IDX_ENABLE_B) begin
      enableB_ff <= wData_ff & FLAGS_B_MASK;
    end
  end

  // ==========================================================
  // Reset cause status
  // Power-on clears both bits; brown-out clears its own bit
  // With the detector off its pulse is ignored, value left as is
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resetCause_ff <= REG_RESET;
    end else if (brownoutReset && brownoutDetectorEnable) begin
      resetCause_ff[BIT_BOR] <= 1'b0;
    end else if (wrEn && wrIdx == IDX_RESET_CAUSE) begin
      resetCause_ff <= wData_ff & RESET_CAUSE_MASK;
    end
  end

  // ==========================================================
  // Event routing into the flag bank
  always_comb begin
    fl.setA = 8'h00;
    fl.setB = 8'h00;
    fl.setA[BIT_CONVERTER] = converterDone;
    fl.setA[BIT_SERIAL] = serialDone;
    // Unused while the unit runs pulse width
    fl.setA[BIT_CAPCMP] = capcmpEvent && (capcmpMode == CC_CAPTURE || capcmpMode == CC_COMPARE);
    fl.setA[BIT_TIMER_B] = timerBMatch;
    fl.setA[BIT_TIMER_A] = timerAOverflow;
    fl.setB[BIT_NV_WRITE] = nvWriteDone;
  end

  assign fl.wdata = wData_ff;
  assign fl.wrA = wrEn && wrIdx == IDX_FLAGS_A;
  assign fl.wrB = wrEn && wrIdx == IDX_FLAGS_B;

  // Sticky flag storage
  event_flags u_flags (
    .clock(clock),
    .arst_n(arst_n),
    .fl(fl.bank)
  );

  // ==========================================================
  // Program counter
  // Priority: reset causes, bus write, then core requests
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= PC_RESET;
    end else if (anyReset) begin
      pc_ff <= PC_RESET;
    end else if (wrEn && wrIdx == IDX_PC_LOW) begin
      pc_ff <= {pcLatch_ff[4:0], wData_ff};
    end else if (callReq || gotoReq) begin
      pc_ff <= {pcLatch_ff[4:3], targetAddr};
    end else if (vectorReq) begin
      pc_ff <= INT_VECTOR;
    end else if (popReq) begin
      pc_ff <= st.topData;
    end else if (stepReq) begin
      pc_ff <= pc_ff + 13'h0001;
    end
  end

  // ==========================================================
  // Return stack traffic
  // Save the counter on call or vector, restore on any return
  assign st.push = !anyReset && !(wrEn && wrIdx == IDX_PC_LOW) && (callReq || (vectorReq && !gotoReq));
  assign st.pop = !anyReset && !(wrEn && wrIdx == IDX_PC_LOW) && popReq &&
                  !(callReq || gotoReq || vectorReq);
  assign st.pushData = pc_ff;

  // Hidden eight-deep stack
  return_stack u_stack (
    .clock(clock),
    .arst_n(arst_n),
    .st(st.stack)
  );

  // ==========================================================
  // Peripheral interrupt request
  // Flag and enable, then peripheral and global enables
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= globalCtl_ff[BIT_GIE] && globalCtl_ff[BIT_PERIPHERAL_IRQ_ENABLE] &&
                (|(fl.flagsA & enableA_ff) || |(fl.flagsB & enableB_ff));
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
  assign pcOut = pc_ff;
  assign peripheralIrq = irq_ff;
endmodule

// [dv/core_side_model.sv]
// Stand-in for the instruction core and the peripherals.
// Assumes the bench calls pulse just after a rising edge.
`timescale 1ns/1ns
module core_side_model (
  input wire logic clock,
  output logic [10:0] ev,
  output logic [10:0] targetAddr
);
  // Idle: no pulse, target scrambled
  initial begin
    ev = 11'h000;
    targetAddr = 11'h7FF;
  end
  // One-cycle event or core pulse, then one idle cycle
  task automatic pulse(input logic [10:0] v, input logic [10:0] t);
    ev <= v;
    targetAddr <= t;
    @(posedge clock);
    ev <= 11'h000;
    targetAddr <= ~t;
    @(posedge clock);
  endtask
endmodule

// [dv/core_flags_pc_stack_indirect_asserts.sv]
// Port checker for the core flag, counter and stack block.
// Assumes it is bound to the top module.
`timescale 1ns/1ns
module core_flags_pc_stack_indirect_asserts
  import core_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic stepReq,
  input wire logic gotoReq,
  input wire logic callReq,
  input wire logic vectorReq,
  input wire logic popReq,
  input wire logic [10:0] targetAddr,
  input wire logic brownoutReset,
  input wire logic otherReset,
  input wire logic brownoutDetectorEnable,
  input wire logic [12:0] pcOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // A bus store is due at the next edge
  wire pend = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  // No reset and no store compete with the core
  wire quiet = !pend && !otherReset && !brownoutReset;
  chk_jump_target: assert property ((callReq || gotoReq) && quiet |=> pcOut[10:0] == $past(targetAddr))
    else $error("jump target not loaded");
  chk_vector_load: assert property (vectorReq && !callReq && !gotoReq && quiet |=> pcOut == INT_VECTOR)
    else $error("vector not loaded");
  chk_step_incr: assert property (stepReq && !callReq && !gotoReq && !vectorReq && !popReq && quiet
    |=> pcOut == $past(pcOut) + 13'h0001)
    else $error("step did not advance");
  chk_plain_reset: assert property (otherReset |=> pcOut == PC_RESET)
    else $error("reset left counter");
  chk_brown_reset: assert property (brownoutReset && brownoutDetectorEnable |=> pcOut == PC_RESET)
    else $error("brown-out left counter");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule
bind core_flags_pc_stack_indirect core_flags_pc_stack_indirect_asserts u_chk (.clock, .arst_n,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .stepReq, .gotoReq, .callReq,
  .vectorReq, .popReq, .targetAddr, .brownoutReset, .otherReset, .brownoutDetectorEnable, .pcOut);

// [dv/core_flags_pc_stack_indirect_bench.sv]
// Self-checking bench for the core flag, counter and stack block.
// Assumes the side model drives core and event pulses.
`timescale 1ns/1ns
module core_flags_pc_stack_indirect_bench;
  import core_pkg::*;
  localparam logic [8:0] REGS [4] = '{IDX_FLAGS_A, IDX_FLAGS_B, IDX_ENABLE_B, IDX_RESET_CAUSE};
  localparam int FB [6] = '{6, 3, 2, 1, 0, 4};
  logic clock, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, peripheralIrq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic converterDone, serialDone, capcmpEvent, timerBMatch, timerAOverflow, nvWriteDone;
  logic stepReq, gotoReq, callReq, vectorReq, popReq, brownoutReset, otherReset, brownoutDetectorEnable;
  logic [10:0] targetAddr, ev, tg;
  logic [12:0] pcOut, pc;
  logic [12:0] stk [8];
  logic [7:0] d;
  logic [4:0] lat;
  logic [2:0] sp;
  capcmp_mode_t capcmpMode;
  int fails, nTests;
  assign {converterDone, serialDone, capcmpEvent, timerBMatch, timerAOverflow, nvWriteDone,
    stepReq, gotoReq, callReq, vectorReq, popReq} = ev;
  core_flags_pc_stack_indirect u_core_flags_pc_stack_indirect (.*);
  core_side_model u_core_side_model (.clock, .ev, .targetAddr);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Implemented bits of a register
  function automatic logic [7:0] impl(input logic [8:0] idx);
    return idx == IDX_FLAGS_A ? FLAGS_A_MASK : idx == IDX_RESET_CAUSE ? RESET_CAUSE_MASK : FLAGS_B_MASK;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
    s_axi_awaddr <= {1'b0, idx, 2'b00};
    s_axi_wdata <= 32'(v);
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    cmp(s_axi_bresp, er);
    s_axi_bready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [8:0] idx, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= {1'b0, idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    cmp(s_axi_rdata, 32'(v));
    cmp(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
    @(posedge clock);
  endtask
  task automatic give_verdict;
    $display("fails=%0d tests=%0d", fails, nTests);
    if (fails == 0 && nTests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Watchdog, well past the test length
  initial begin
    #200000;
    fails++;
    give_verdict();
  end
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, otherReset} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, brownoutReset, sp} = '0;
    s_axi_wstrb = 4'hF;
    brownoutDetectorEnable = 1'b1;
    capcmpMode = CC_CAPTURE;
    {arst_n, fails, nTests} = '0;
    void'($urandom(32'hDBBB9D7C));
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    foreach (REGS[i]) begin
      d = 8'($urandom);
      rd(REGS[i], 8'h00);
      wr(REGS[i], d);
      rd(REGS[i], d & impl(REGS[i]));
      wr(REGS[i], 8'h00);
    end
    rd(9'h1FF, 8'h00, RESP_SLVERR);
    wr(9'h1FF, 8'h5A, RESP_SLVERR);
    $display("register test done");
    capcmpMode <= capcmp_mode_t'(2'($urandom_range(1, 0)));
    for (int k = 0; k < 6; k++) begin
      u_core_side_model.pulse(11'h400 >> k, 11'h000);
      rd(REGS[k/5], 8'h01 << FB[k]);
      rd(REGS[k/5], 8'h01 << FB[k]);
      wr(REGS[k/5], 8'h00);
    end
    capcmpMode <= CC_PWM;
    u_core_side_model.pulse(11'h100, 11'h000);
    rd(IDX_FLAGS_A, 8'h00);
    wr(IDX_ENABLE_B, 8'h10);
    wr(IDX_GLOBAL, 8'hC0);
    u_core_side_model.pulse(11'h020, 11'h000);
    @(posedge clock);
    cmp(peripheralIrq, 32'h1);
    wr(IDX_GLOBAL, 8'h80);
    cmp(peripheralIrq, 32'h0);
    wr(IDX_FLAGS_B, 8'h00);
    $display("event test done");
    lat = 5'($urandom);
    d = 8'($urandom);
    wr(IDX_PC_LATCH, {3'h0, lat});
    wr(IDX_PC_LOW, d);
    pc = {lat, d};
    cmp(pcOut, pc);
    rd(IDX_PC_LOW, d);
    for (int k = 0; k < 9; k++) begin
      tg = 11'($urandom);
      stk[sp] = pc;
      sp++;
      u_core_side_model.pulse(k == 8 ? 11'h002 : 11'h004, tg);
      pc = k == 8 ? INT_VECTOR : {lat[4:3], tg};
      cmp(pcOut, pc);
    end
    for (int k = 0; k < 9; k++) begin
      sp--;
      u_core_side_model.pulse(11'h001, 11'h000);
      cmp(pcOut, stk[sp]);
    end
    rd(IDX_PC_LATCH, {3'h0, lat});
    tg = 11'($urandom);
    u_core_side_model.pulse(11'h008, tg);
    u_core_side_model.pulse(11'h010, 11'h000);
    cmp(pcOut, {lat[4:3], tg} + 13'h0001);
    otherReset <= 1'b1;
    @(posedge clock);
    otherReset <= 1'b0;
    @(posedge clock);
    cmp(pcOut, PC_RESET);
    wr(IDX_RESET_CAUSE, 8'h03);
    brownoutReset <= 1'b1;
    @(posedge clock);
    brownoutReset <= 1'b0;
    @(posedge clock);
    rd(IDX_RESET_CAUSE, 8'h02);
    $display("counter test done");
    wr(IDX_POINTER, IDX_FLAGS_A[7:0]);
    wr(IDX_INDIRECT, 8'hFF);
    rd(IDX_FLAGS_A, FLAGS_A_MASK);
    rd(IDX_INDIRECT, FLAGS_A_MASK);
    wr(IDX_POINTER, 8'h00);
    wr(IDX_INDIRECT, 8'h5A);
    rd(IDX_INDIRECT, 8'h00);
    wr(IDX_STATUS, 8'h80);
    rd(IDX_INDIRECT, 8'h00, RESP_SLVERR);
    $display("indirect test done");
    give_verdict();
  end
endmodule
